// ---- rtl/perf_pkg.sv ----
// Shared constants, field layout and carrier types of the event counters.
package perf_pkg;

  localparam int NUM_PAIRS   = 4;
  localparam int NUM_HALVES  = 2 * NUM_PAIRS;
  localparam int CTR_W       = 32;
  localparam int SEL_W       = 7;
  localparam int NUM_EVENTS  = 2 ** SEL_W;
  localparam int PAIR_SEL_W  = 3;
  localparam int PAIR_IDX_W  = 2;
  localparam int OVF_W       = 16;
  localparam int WORD_W      = 64;

  // Control register field positions.
  localparam int UPPER_SEL_LSB   = 11;
  localparam int LOWER_SEL_LSB   = 4;
  localparam int SELECT_LOCK_BIT = 3;
  localparam int USER_EN_BIT     = 2;
  localparam int SYS_EN_BIT      = 1;
  localparam int RESTRICT_BIT    = 0;
  localparam int PAIR_SEL_LSB    = 18;
  localparam int PAIR_COUNT_LSB  = 22;
  localparam int OVF_LOCK_BIT    = 26;
  localparam int OVF_LSB         = 32;

  localparam logic [2:0] PAIR_COUNT_VAL = 3'h3;

  // Reset values of the control state and counters, and the counter maximum.
  localparam logic [SEL_W-1:0]      SEL_RST      = 7'h00;
  localparam logic [PAIR_SEL_W-1:0] PAIR_SEL_RST = 3'h0;
  localparam logic                  USER_EN_RST  = 1'b0;
  localparam logic                  SYS_EN_RST   = 1'b0;
  localparam logic                  RESTRICT_RST = 1'b0;
  localparam logic [NUM_HALVES-1:0] OVF_RST      = 8'h00;
  localparam logic [CTR_W-1:0]      CTR_RST      = 32'h0000_0000;
  localparam logic [CTR_W-1:0]      CTR_MAX      = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {
    OP_READ_CTL,
    OP_WRITE_CTL,
    OP_READ_CTR,
    OP_WRITE_CTR
  } access_op_t;

  typedef struct packed {
    logic              valid;
    access_op_t        op;
    logic [WORD_W-1:0] wdata;
  } access_req_t;

  typedef struct packed {
    logic              done;
    logic              fault;
    logic [WORD_W-1:0] rdata;
  } access_rsp_t;

  localparam access_rsp_t RSP_RST = '{done: 1'b0, fault: 1'b0, rdata: '0};

endpackage : perf_pkg

// ---- rtl/perf_event_counters.sv ----
// Performance event counters with their control register and access checks.
module perf_event_counters
  import perf_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // Register access instructions.
  input  wire access_req_t           req,
  input  wire logic                  privileged_mode_flag,
  output access_rsp_t                rsp,
  // Event occurrences, one bit per event code.
  input  wire logic [NUM_EVENTS-1:0] events,
  // Overflow signalling toward the trap logic.
  output logic                       soft_interrupt_reg_ovf_set,
  output logic                       irq_level15
);

  logic [SEL_W-1:0]      upper_event_select_q [NUM_PAIRS];
  logic [SEL_W-1:0]      upper_event_select_d [NUM_PAIRS];
  logic [SEL_W-1:0]      lower_event_select_q [NUM_PAIRS];
  logic [SEL_W-1:0]      lower_event_select_d [NUM_PAIRS];
  logic [PAIR_SEL_W-1:0] pair_select_q;
  logic [PAIR_SEL_W-1:0] pair_select_d;
  logic                  user_count_enable_q;
  logic                  user_count_enable_d;
  logic                  system_count_enable_q;
  logic                  system_count_enable_d;
  logic                  access_restrict_q;
  logic                  access_restrict_d;
  logic [NUM_HALVES-1:0] overflow_status_q;
  logic [NUM_HALVES-1:0] overflow_status_d;
  logic [CTR_W-1:0]      counter_q [NUM_HALVES];
  logic [CTR_W-1:0]      counter_d [NUM_HALVES];
  access_rsp_t           rsp_q;
  access_rsp_t           rsp_d;
  logic                  irq_q;
  logic                  irq_d;

  logic                  count_allowed;
  logic [NUM_HALVES-1:0] hw_overflow;
  logic                  fault;
  logic [PAIR_IDX_W-1:0] cur_pair;
  logic [PAIR_IDX_W-1:0] new_pair;
  logic [SEL_W-1:0]      half_select;

  // Builds the readback word of the control register.
  function automatic logic [WORD_W-1:0] control_word(
    input logic [SEL_W-1:0]      usel,
    input logic [SEL_W-1:0]      lsel,
    input logic [PAIR_SEL_W-1:0] psel,
    input logic                  uen,
    input logic                  sen,
    input logic                  restricted,
    input logic [NUM_HALVES-1:0] ovf
  );
    logic [WORD_W-1:0] w;
    w = '0;
    w[OVF_LSB +: NUM_HALVES] = ovf;
    w[PAIR_COUNT_LSB +: 3] = PAIR_COUNT_VAL;
    w[PAIR_SEL_LSB +: PAIR_SEL_W] = psel;
    w[UPPER_SEL_LSB +: SEL_W] = usel;
    w[LOWER_SEL_LSB +: SEL_W] = lsel;
    w[SELECT_LOCK_BIT] = 1'b0;
    w[OVF_LOCK_BIT] = 1'b0;
    w[USER_EN_BIT] = uen;
    w[SYS_EN_BIT] = sen;
    w[RESTRICT_BIT] = restricted;
    return w;
  endfunction : control_word

  // Only the low two pair-select bits address the four implemented pairs.
  assign cur_pair = pair_select_q[PAIR_IDX_W-1:0];
  assign new_pair = req.wdata[PAIR_SEL_LSB +: PAIR_IDX_W];

  // One mode enable is chosen by the current privilege, for every half.
  assign count_allowed = privileged_mode_flag ? system_count_enable_q
                                              : user_count_enable_q;

  always_comb begin
    for (int p = 0; p < NUM_PAIRS; p++) begin
      upper_event_select_d[p] = upper_event_select_q[p];
      lower_event_select_d[p] = lower_event_select_q[p];
    end
    pair_select_d         = pair_select_q;
    user_count_enable_d   = user_count_enable_q;
    system_count_enable_d = system_count_enable_q;
    access_restrict_d     = access_restrict_q;
    overflow_status_d     = overflow_status_q;
    hw_overflow           = '0;
    half_select           = '0;
    rsp_d                 = RSP_RST;
    fault                 = 1'b0;

    // Event counting; a half steps by one per occurrence of its event.
    for (int h = 0; h < NUM_HALVES; h++) begin
      counter_d[h] = counter_q[h];
      half_select = h[0] ? upper_event_select_q[h / 2]
                         : lower_event_select_q[h / 2];
      if (count_allowed && events[half_select]) begin
        counter_d[h] = counter_q[h] + 32'h0000_0001;
        if (counter_q[h] == CTR_MAX) begin
          hw_overflow[h] = 1'b1;
        end
      end
    end

    if (req.valid) begin
      if (!privileged_mode_flag) begin
        if (access_restrict_q) begin
          fault = 1'b1;
        end else if (req.op == OP_WRITE_CTL && req.wdata[RESTRICT_BIT]) begin
          fault = 1'b1;
        end
      end
      rsp_d.done  = 1'b1;
      rsp_d.fault = fault;
      if (!fault) begin
        unique case (req.op)
          OP_READ_CTL: begin
            rsp_d.rdata = control_word(upper_event_select_q[cur_pair],
                                       lower_event_select_q[cur_pair],
                                       pair_select_q,
                                       user_count_enable_q,
                                       system_count_enable_q,
                                       access_restrict_q,
                                       overflow_status_q);
          end
          OP_READ_CTR: begin
            rsp_d.rdata = {counter_q[{cur_pair, 1'b1}],
                           counter_q[{cur_pair, 1'b0}]};
          end
          OP_WRITE_CTR: begin
            // A write wins over a count step in the same cycle.
            counter_d[{cur_pair, 1'b0}] = req.wdata[CTR_W-1:0];
            counter_d[{cur_pair, 1'b1}] = req.wdata[WORD_W-1:CTR_W];
            hw_overflow[{cur_pair, 1'b0}] = 1'b0;
            hw_overflow[{cur_pair, 1'b1}] = 1'b0;
          end
          OP_WRITE_CTL: begin
            pair_select_d = req.wdata[PAIR_SEL_LSB +: PAIR_SEL_W];
            user_count_enable_d   = req.wdata[USER_EN_BIT];
            system_count_enable_d = req.wdata[SYS_EN_BIT];
            access_restrict_d     = req.wdata[RESTRICT_BIT];
            // The selects written land in the newly selected pair.
            if (!req.wdata[SELECT_LOCK_BIT]) begin
              upper_event_select_d[new_pair] =
                req.wdata[UPPER_SEL_LSB +: SEL_W];
              lower_event_select_d[new_pair] =
                req.wdata[LOWER_SEL_LSB +: SEL_W];
            end
            if (!req.wdata[OVF_LOCK_BIT]) begin
              overflow_status_d = req.wdata[OVF_LSB +: NUM_HALVES];
            end
          end
        endcase
      end
    end

    // Hardware overflow wins over a clearing write in the same cycle.
    overflow_status_d = overflow_status_d | hw_overflow;
    // Only hardware overflow interrupts; written ones never do.
    irq_d = |hw_overflow;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        upper_event_select_q[p] <= SEL_RST;
        lower_event_select_q[p] <= SEL_RST;
      end
      for (int h = 0; h < NUM_HALVES; h++) begin
        counter_q[h] <= CTR_RST;
      end
      pair_select_q         <= PAIR_SEL_RST;
      user_count_enable_q   <= USER_EN_RST;
      system_count_enable_q <= SYS_EN_RST;
      access_restrict_q     <= RESTRICT_RST;
      overflow_status_q     <= OVF_RST;
      rsp_q                 <= RSP_RST;
      irq_q                 <= 1'b0;
    end else begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        upper_event_select_q[p] <= upper_event_select_d[p];
        lower_event_select_q[p] <= lower_event_select_d[p];
      end
      for (int h = 0; h < NUM_HALVES; h++) begin
        counter_q[h] <= counter_d[h];
      end
      pair_select_q         <= pair_select_d;
      user_count_enable_q   <= user_count_enable_d;
      system_count_enable_q <= system_count_enable_d;
      access_restrict_q     <= access_restrict_d;
      overflow_status_q     <= overflow_status_d;
      rsp_q                 <= rsp_d;
      irq_q                 <= irq_d;
    end
  end

  assign rsp             = rsp_q;
  assign soft_interrupt_reg_ovf_set = irq_q;
  assign irq_level15     = irq_q;

endmodule : perf_event_counters

// ---- tb/perf_event_counters_checker.sv ----
// Port-level assertions for the performance event counters.
module perf_event_counters_checker
  import perf_pkg::*;
(
  // Watched ports.
  input wire logic                  clock,
  input wire logic                  arst_n,
  input wire access_req_t           req,
  input wire logic                  privileged_mode_flag,
  input wire access_rsp_t           rsp,
  input wire logic [NUM_EVENTS-1:0] events,
  input wire logic                  soft_interrupt_reg_ovf_set,
  input wire logic                  irq_level15
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  chk_done_follows: assert property (req.valid |=> rsp.done)
    else $error("request without answer");
  chk_done_cause: assert property (rsp.done |-> $past(req.valid))
    else $error("answer without request");
  chk_user_restrict: assert property (req.valid && !privileged_mode_flag
    && req.op == OP_WRITE_CTL && req.wdata[RESTRICT_BIT] |=> rsp.fault)
    else $error("unprivileged restrict write not refused");
  chk_access_restrict_allowed: assert property (req.valid && privileged_mode_flag
    |=> rsp.done && !rsp.fault)
    else $error("privileged access refused");
  chk_fault_quiet: assert property (rsp.fault |-> rsp.rdata == '0)
    else $error("refused access returned data");
  chk_lock_bits_zero: assert property ($past(req.valid)
    && $past(req.op) == OP_READ_CTL && !rsp.fault
    |-> !rsp.rdata[SELECT_LOCK_BIT] && !rsp.rdata[OVF_LOCK_BIT])
    else $error("lock bits read nonzero");
  chk_pair_count: assert property ($past(req.valid)
    && $past(req.op) == OP_READ_CTL && !rsp.fault
    |-> rsp.rdata[24:22] == PAIR_COUNT_VAL && rsp.rdata[47:40] == 8'h00)
    else $error("pair count field wrong");
  chk_irq_pair: assert property (soft_interrupt_reg_ovf_set == irq_level15)
    else $error("overflow pulses differ");
  chk_ovf_cause: assert property (soft_interrupt_reg_ovf_set |-> $past(|events))
    else $error("overflow pulse without event");
endmodule : perf_event_counters_checker

bind perf_event_counters perf_event_counters_checker checker_inst (
  .clock(clock), .arst_n(arst_n), .req(req),
  .privileged_mode_flag(privileged_mode_flag), .rsp(rsp), .events(events),
  .soft_interrupt_reg_ovf_set(soft_interrupt_reg_ovf_set), .irq_level15(irq_level15));

// ---- tb/test_perf_event_counters.sv ----
// Self-checking bench for the performance event counters.
module test_perf_event_counters
  import perf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clock;
  logic                  arst_n;
  access_req_t           req;
  logic                  access_restrict_mode;
  access_rsp_t           rsp;
  logic [NUM_EVENTS-1:0] events;
  logic                  soft_interrupt_reg_ovf_set;
  logic                  irq_level15;
  logic [64:0]           notes[$];
  logic [64:0]           e;
  logic [6:0]            u;
  logic [6:0]            l;
  logic [2:0]            p;
  logic [7:0]            ov;
  int                    failures;
  int                    samples_checked;
  int                    pulses;

  perf_event_counters perf_event_counters_inst (
    .clock(clock), .arst_n(arst_n), .req(req),
    .privileged_mode_flag(access_restrict_mode), .rsp(rsp), .events(events),
    .soft_interrupt_reg_ovf_set(soft_interrupt_reg_ovf_set), .irq_level15(irq_level15));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function automatic logic [63:0] wv(logic [6:0] su, logic [6:0] sl,
      logic [3:0] lo, logic olk, logic [7:0] sts);
    return {24'h0, sts, 5'h0, olk, 5'h0, p, su, sl, lo};
  endfunction : wv

  function automatic logic [63:0] rv(logic [6:0] su, logic [6:0] sl,
      logic [3:0] lo, logic [7:0] sts);
    return {24'h0, sts, 6'h0, 5'h06, p, su, sl, 1'b0, lo[2:0]};
  endfunction : rv

  task automatic acc(access_op_t op, logic [63:0] wd, logic pv,
      logic [64:0] ex);
    @(negedge clock);
    req = '{valid: 1'b1, op: op, wdata: wd};
    access_restrict_mode = pv;
    notes.push_back(ex);
  endtask : acc

  task automatic ev(logic pv, int n);
    @(negedge clock);
    req.valid = 1'b0;
    access_restrict_mode = pv;
    for (int i = 0; i < n; i++) begin
      events[u] = 1'b1;
      events[l] = 1'b1;
      @(negedge clock);
      events = '0;
      @(negedge clock);
    end
  endtask : ev

  task automatic complete_run();
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  always @(negedge clock) begin
    if (soft_interrupt_reg_ovf_set === 1'b1 && irq_level15 === 1'b1) begin
      pulses++;
    end
    if (rsp.done === 1'b1) begin
      e = notes.size() > 0 ? notes.pop_front() : 'x;
      samples_checked++;
      if ({rsp.fault, rsp.rdata} !== e) begin
        failures++;
        $display("ERROR %0t response mismatch", $time);
      end
    end
  end

  initial begin
    #20000;
    failures++;
    complete_run();
  end

  initial begin
    failures = 0;
    samples_checked = 0;
    pulses = 0;
    arst_n = 1'b0;
    req = '0;
    access_restrict_mode = 1'b1;
    events = '0;
    u = 7'($urandom(89527));
    l = 7'($urandom);
    p = 3'($urandom);
    ov = 8'h03 << (2 * p[1:0]);
    repeat (16) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    acc(OP_READ_CTL, '0, 1'b1, {1'b0, 64'h0000_0000_00C0_0000});
    acc(OP_WRITE_CTL, wv(u, l, 4'h6, 1'b1, 8'hFF), 1'b1, '0);
    acc(OP_READ_CTL, '0, 1'b1, {1'b0, rv(u, l, 4'h6, 8'h00)});
    acc(OP_WRITE_CTL, wv(~u, ~l, 4'hE, 1'b0, 8'hFF), 1'b1, '0);
    acc(OP_READ_CTL, '0, 1'b1, {1'b0, rv(u, l, 4'h6, 8'hFF)});
    acc(OP_WRITE_CTL, wv(u, l, 4'h4, 1'b0, 8'h00), 1'b1, '0);
    acc(OP_WRITE_CTR, 64'hFFFF_FFFF_FFFF_FFFF, 1'b1, '0);
    ev(1'b1, 1);
    acc(OP_READ_CTR, '0, 1'b1, {1'b0, 64'hFFFF_FFFF_FFFF_FFFF});
    ev(1'b0, 1);
    acc(OP_READ_CTR, '0, 1'b1, '0);
    acc(OP_READ_CTL, '0, 1'b1, {1'b0, rv(u, l, 4'h4, ov)});
    ev(1'b0, 2);
    acc(OP_READ_CTR, '0, 1'b0, {1'b0, 64'h0000_0002_0000_0002});
    acc(OP_WRITE_CTL, wv(u, l, 4'h5, 1'b0, 8'h00), 1'b0, {1'b1, 64'h0});
    acc(OP_WRITE_CTL, wv(u, l, 4'h5, 1'b1, 8'h00), 1'b1, '0);
    acc(OP_READ_CTR, '0, 1'b0, {1'b1, 64'h0});
    acc(OP_READ_CTL, '0, 1'b1, {1'b0, rv(u, l, 4'h5, ov)});
    ev(1'b1, 0);
    repeat (3) @(negedge clock);
    samples_checked++;
    if (pulses !== 1 || notes.size() != 0) begin
      failures++;
      $display("ERROR %0t overflow pulse count", $time);
    end
    complete_run();
  end
endmodule : test_perf_event_counters
